// ---- src/pio_pkg.sv ----
// pio_pkg: register map, field widths and option codes of the parallel port block
// assumes one clock domain and a byte-wide register port from the processor
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package pio_pkg;
    localparam int PIO_ADDR_W = 4;
    localparam int PIO_DATA_W = 8;
    localparam int PIO_IN_W = 7;
    // register offsets
    localparam logic [PIO_ADDR_W-1:0] PIO_FIRST_VALUE = 4'h0;
    localparam logic [PIO_ADDR_W-1:0] PIO_SECOND_VALUE = 4'h1;
    localparam logic [PIO_ADDR_W-1:0] PIO_THIRD_VALUE = 4'h2;
    localparam logic [PIO_ADDR_W-1:0] PIO_INPUT_VALUE = 4'h3;
    localparam logic [PIO_ADDR_W-1:0] PIO_FIRST_DIR = 4'h4;
    localparam logic [PIO_ADDR_W-1:0] PIO_SECOND_DIR = 4'h5;
    localparam logic [PIO_ADDR_W-1:0] PIO_THIRD_DIR = 4'h6;
    localparam logic [PIO_ADDR_W-1:0] PIO_SERIAL_CTRL = 4'h7;
    // reset values
    localparam logic [PIO_DATA_W-1:0] PIO_DIR_RESET = 8'h00;
    localparam logic [PIO_DATA_W-1:0] PIO_ZERO = 8'h00;
    localparam logic [PIO_IN_W-1:0] PIO_IN_ZERO = 7'h00;
    // trigger sensitivity option codes
    localparam logic PIO_TRIG_EDGE = 1'b0;
    localparam logic PIO_TRIG_EDGE_LEVEL = 1'b1;
    // serial override field layout inside the serial control register
    localparam int PIO_SYNC_LSB = 0;
    localparam int PIO_SYNC_W = 4;
    localparam int PIO_ASYNC_LSB = 4;
    localparam int PIO_ASYNC_W = 2;
endpackage

// ---- src/pio_ports.sv ----
// pio_ports: three bidirectional byte ports, one input-only port, merged interrupt
// assumes pins synchronous to clk_sys; processor uses simple strobe port
`timescale 1ns/100ps
`default_nettype none
module pio_ports
    import pio_pkg::*;
#(
    parameter logic [PIO_DATA_W-1:0] IRQ_OPTION = 8'h00, // per-pin fabrication choice
    parameter logic TRIG_MODE = PIO_TRIG_EDGE // edge-only or edge-and-level
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [pio_pkg::PIO_ADDR_W-1:0] reg_addr,
    input wire logic [pio_pkg::PIO_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pio_pkg::PIO_DATA_W-1:0] reg_rdata,
    // first port pins
    input wire logic [pio_pkg::PIO_DATA_W-1:0] first_in,
    output logic [pio_pkg::PIO_DATA_W-1:0] first_out,
    output logic [pio_pkg::PIO_DATA_W-1:0] first_oe,
    // second port pins
    input wire logic [pio_pkg::PIO_DATA_W-1:0] second_in,
    output logic [pio_pkg::PIO_DATA_W-1:0] second_out,
    output logic [pio_pkg::PIO_DATA_W-1:0] second_oe,
    output logic [pio_pkg::PIO_DATA_W-1:0] second_pullup,
    // third port pins
    input wire logic [pio_pkg::PIO_DATA_W-1:0] third_in,
    output logic [pio_pkg::PIO_DATA_W-1:0] third_out,
    output logic [pio_pkg::PIO_DATA_W-1:0] third_oe,
    // input-only port and serial overrides
    input wire logic [pio_pkg::PIO_IN_W-1:0] fourth_in,
    output logic [pio_pkg::PIO_IN_W-1:0] fourth_oe_allow,
    // external interrupt
    input wire logic irq_pin_n,
    input wire logic irq_ack,
    output logic irq_req
);
    import pio_pkg::*;

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    // the serial enables must fit the byte-wide register
    if (PIO_SYNC_W + PIO_ASYNC_W > PIO_DATA_W) begin : g_bad_serial_w
        $error("pio_ports: serial enable field wider than a byte");
    end
    // the input-only port needs a spare top bit in the read byte
    if (PIO_IN_W >= PIO_DATA_W) begin : g_bad_in_w
        $error("pio_ports: input-only port too wide");
    end
    // only the two trigger codes of the package are served
    if (TRIG_MODE != PIO_TRIG_EDGE && TRIG_MODE != PIO_TRIG_EDGE_LEVEL) begin : g_bad_mode
        $error("pio_ports: bad trigger mode");
    end

    // ---------------------------------------------------------------
    // behaviour notes
    // ---------------------------------------------------------------
    // register map
    // - every register is one byte wide; bit n of a port register
    //   belongs to pin n of that port
    // - offsets 0 to 2 hold the three port values, 4 to 6 their
    //   directions, 3 the input-only port and 7 the serial enables
    // - unmapped reads return zero and unmapped writes are dropped
    // reset
    // - the data latches carry no reset: a reset keeps what software
    //   wrote, and a latch never written holds an unknown value
    // - the direction registers clear on reset, so every pin comes up
    //   as an input and nothing is driven until software asks for it
    // - the serial enables clear too, so the input-only pins come up
    //   as plain inputs whatever the serial blocks want
    // pin drive
    // - pin outputs and enables are registered, so a write strobe in
    //   cycle c shows on the pins in cycle c+2
    // - out is masked by direction; an input pin shows zero on out,
    //   which keeps the pad driver quiet whatever the latch holds
    // - writing the latch before the direction keeps the pin from
    //   showing a stale value for a cycle when it turns to output
    // register read
    // - a port read mixes per bit: live pin where the bit is an input,
    //   latch where it is an output
    // - read data stand one cycle after the strobe and are zero
    //   otherwise, so an idle bus reads as zero
    // - the input-only port passes a two-stage synchroniser, so a read
    //   sees the pins as they stood three cycles before the data cycle
    // - the serial enable register only permits the serial blocks to
    //   take over pins; the pins stay inputs of this block regardless
    // interrupt
    // - second-port pins with the interrupt option get a pullup while
    //   they are inputs and join the external request while low
    // - a switch from output to input on such a pin can raise a false
    //   request unless software presets the latch high first
    // - the request latch sets on the rising edge of the merged line;
    //   a set in the cycle of an acknowledge wins over the clear
    // - in edge-and-level mode a line that stays active keeps the
    //   request up after the acknowledge
    // - the request reaches irq_req three cycles after the line rises in edge-only mode, two in edge-and-level mode
    // limitations
    // - pins are taken as synchronous to clk_sys; only the input-only
    //   port is resynchronised, the others feed the read mux directly
    // - a line that is already active when reset releases counts as a
    //   new edge one cycle later

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [PIO_DATA_W-1:0] first_latch_q; // data latches, not reset
    logic [PIO_DATA_W-1:0] second_latch_q;
    logic [PIO_DATA_W-1:0] third_latch_q;
    logic [PIO_DATA_W-1:0] first_dir_q; // direction registers
    logic [PIO_DATA_W-1:0] second_dir_q;
    logic [PIO_DATA_W-1:0] third_dir_q;
    logic [PIO_SYNC_W+PIO_ASYNC_W-1:0] serial_ctrl_q; // special driver enables
    logic [PIO_IN_W-1:0] fourth_s1_q; // input-only synchroniser stages
    logic [PIO_IN_W-1:0] fourth_s2_q;
    logic wr_hit;
    assign wr_hit = reg_wr;

    // ---------------------------------------------------------------
    // decoded write strobes
    // ---------------------------------------------------------------
    // one strobe per register that is loaded outside the direction case
    logic wr_first_value; // write to the first port value
    logic wr_second_value; // write to the second port value
    logic wr_third_value; // write to the third port value
    logic wr_serial; // write to the serial driver enables
    assign wr_first_value = wr_hit && (reg_addr == PIO_FIRST_VALUE);
    assign wr_second_value = wr_hit && (reg_addr == PIO_SECOND_VALUE);
    assign wr_third_value = wr_hit && (reg_addr == PIO_THIRD_VALUE);
    assign wr_serial = wr_hit && (reg_addr == PIO_SERIAL_CTRL);

    // ---------------------------------------------------------------
    // per-port read views
    // ---------------------------------------------------------------
    logic [PIO_DATA_W-1:0] first_view; // live pin where input, latch where output
    logic [PIO_DATA_W-1:0] second_view; // same mix for the second port
    logic [PIO_DATA_W-1:0] third_view; // same mix for the third port

    // each bit chooses by its own direction bit, so mixed ports read right
    always_comb begin
        first_view = (first_latch_q & first_dir_q) | (first_in & ~first_dir_q);
        second_view = (second_latch_q & second_dir_q) | (second_in & ~second_dir_q);
        third_view = (third_latch_q & third_dir_q) | (third_in & ~third_dir_q);
    end

    // data latches load on any write, whatever the direction
    always_ff @(posedge clk_sys) begin
        if (wr_first_value) begin
            first_latch_q <= reg_wdata;
        end
        if (wr_second_value) begin
            second_latch_q <= reg_wdata;
        end
        if (wr_third_value) begin
            third_latch_q <= reg_wdata;
        end
    end

    // direction registers cleared by reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            first_dir_q <= PIO_DIR_RESET;
            second_dir_q <= PIO_DIR_RESET;
            third_dir_q <= PIO_DIR_RESET;
        end else if (wr_hit) begin
            case (reg_addr)
                PIO_FIRST_DIR: first_dir_q <= reg_wdata;
                PIO_SECOND_DIR: second_dir_q <= reg_wdata;
                PIO_THIRD_DIR: third_dir_q <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // serial special-function driver enables, off during reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            serial_ctrl_q <= '0;
        end else if (wr_serial) begin
            serial_ctrl_q <= reg_wdata[PIO_SYNC_W+PIO_ASYNC_W-1:0];
        end
    end

    // input-only port synchroniser
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fourth_s1_q <= PIO_IN_ZERO;
            fourth_s2_q <= PIO_IN_ZERO;
        end else begin
            fourth_s1_q <= fourth_in;
            fourth_s2_q <= fourth_s1_q;
        end
    end

    // ---------------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------------
    // all pin controls come from flip-flops so the pads never see a
    // decode glitch; the cost is one extra cycle after the register
    // update. the pullup follows the direction so an output pin never
    // fights its own pullup
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            first_oe <= PIO_ZERO;
            second_oe <= PIO_ZERO;
            third_oe <= PIO_ZERO;
            first_out <= PIO_ZERO;
            second_out <= PIO_ZERO;
            third_out <= PIO_ZERO;
            second_pullup <= PIO_ZERO;
            fourth_oe_allow <= PIO_IN_ZERO;
        end else begin
            first_oe <= first_dir_q;
            second_oe <= second_dir_q;
            third_oe <= third_dir_q;
            first_out <= first_latch_q & first_dir_q;
            second_out <= second_latch_q & second_dir_q;
            third_out <= third_latch_q & third_dir_q;
            second_pullup <= IRQ_OPTION & ~second_dir_q;
            // low four pins go to sync serial, next two to async serial
            fourth_oe_allow <= {1'b0, serial_ctrl_q};
        end
    end

    // ---------------------------------------------------------------
    // register read: pin for inputs, latch for outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= PIO_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                PIO_FIRST_VALUE: reg_rdata <= first_view;
                PIO_SECOND_VALUE: reg_rdata <= second_view;
                PIO_THIRD_VALUE: reg_rdata <= third_view;
                PIO_INPUT_VALUE: reg_rdata <= {1'b0, fourth_s2_q};
                PIO_FIRST_DIR: reg_rdata <= first_dir_q;
                PIO_SECOND_DIR: reg_rdata <= second_dir_q;
                PIO_THIRD_DIR: reg_rdata <= third_dir_q;
                PIO_SERIAL_CTRL: reg_rdata <= {2'b00, serial_ctrl_q};
                default: reg_rdata <= PIO_ZERO; // unmapped reads zero
            endcase
        end else begin
            reg_rdata <= PIO_ZERO;
        end
    end

    // ---------------------------------------------------------------
    // external interrupt: merge, falling edge latch, synchronise
    // ---------------------------------------------------------------
    logic irq_line; // active-high merged request level
    logic irq_line_q; // previous line level
    logic irq_latch_q; // edge latch
    logic irq_sync_q; // synchronising stage
    // the latch catches the edge at once; the sync stage and the output
    // flop give the request its three-cycle delay in edge-only mode, two in edge-and-level mode. only input pins
    // with the option take part, so an output pin driven low by this
    // block never requests
    // an enabled input pin pulled low requests like the external pin
    assign irq_line = ~irq_pin_n | (|(IRQ_OPTION & ~second_dir_q & ~second_in));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_line_q <= 1'b0;
            irq_latch_q <= 1'b0;
            irq_sync_q <= 1'b0;
            irq_req <= 1'b0;
        end else begin
            irq_line_q <= irq_line;
            // falling edge of the line (rise of active-high) wins over ack
            if (irq_line && !irq_line_q) begin
                irq_latch_q <= 1'b1;
            end else if (irq_ack) begin
                irq_latch_q <= 1'b0;
            end
            irq_sync_q <= irq_latch_q | ((TRIG_MODE == PIO_TRIG_EDGE_LEVEL) && irq_line);
            irq_req <= irq_sync_q;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_dir_reset_clear: assert property (@(posedge clk_sys) $fell(rst) |-> first_dir_q == PIO_DIR_RESET && second_dir_q == PIO_DIR_RESET) else $error("direction not cleared");
    a_oe_follows_dir: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == PIO_THIRD_DIR) |-> ##2 third_oe == $past(reg_wdata, 2)) else $error("oe does not follow direction");
    a_latch_loads: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == PIO_FIRST_VALUE) |=> first_latch_q == $past(reg_wdata)) else $error("latch not loaded");
    a_read_mix: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == PIO_SECOND_VALUE) |=> reg_rdata == (($past(second_latch_q) & $past(second_dir_q)) | ($past(second_in) & ~$past(second_dir_q)))) else $error("port read wrong");
    a_dir_readback: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == PIO_FIRST_DIR) ##1 (reg_rd && reg_addr == PIO_FIRST_DIR) |=> reg_rdata == $past(reg_wdata, 2)) else $error("direction readback wrong");
    a_pullup_input: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> second_pullup == (IRQ_OPTION & ~$past(second_dir_q))) else $error("pullup wrong");
    a_edge_to_req: assert property (@(posedge clk_sys) disable iff (rst)
        (irq_line && !irq_line_q && !irq_ack) |-> ##3 irq_req) else $error("edge not requested");
    a_input_sync: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == PIO_INPUT_VALUE) |=> reg_rdata[PIO_IN_W-1:0] == $past(fourth_in, 3)) else $error("input port read wrong");
    a_serial_off: assert property (@(posedge clk_sys) $fell(rst) |-> fourth_oe_allow == PIO_IN_ZERO) else $error("special drivers on in reset");
    // third direction register also comes out of reset cleared
    a_third_dir_reset: assert property (@(posedge clk_sys)
        $fell(rst) |-> third_dir_q == PIO_DIR_RESET) else $error("third direction not cleared");
    // the first port drives its latch only on output bits
    a_out_masked: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> first_out == ($past(first_latch_q) & $past(first_dir_q))) else $error("output not masked");
    // the third port drives its latch only on output bits
    a_third_masked: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> third_out == ($past(third_latch_q) & $past(third_dir_q))) else $error("third output not masked");
    // first port enables follow the direction register one cycle late
    a_first_oe_dir: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> first_oe == $past(first_dir_q)) else $error("first enable wrong");
    // read data stand only in the cycle after a read strobe
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !reg_rd |=> reg_rdata == PIO_ZERO) else $error("read data not idle");
    // a direction read returns the register contents
    a_dir_read_first: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == PIO_FIRST_DIR) |=> reg_rdata == $past(first_dir_q)) else $error("direction read wrong");
    // serial enables reach the pin permissions two cycles after the write
    a_serial_follow: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == PIO_SERIAL_CTRL) |-> ##2
        fourth_oe_allow == {1'b0, $past(reg_wdata[PIO_SYNC_W+PIO_ASYNC_W-1:0], 2)})
        else $error("serial enable wrong");
    // the top input-only pin has no serial function and never drives
    a_top_never_drive: assert property (@(posedge clk_sys) disable iff (rst)
        fourth_oe_allow[PIO_IN_W-1] == 1'b0) else $error("top input pin enabled");
    // an acknowledge without a new edge clears the latch
    a_ack_clears: assert property (@(posedge clk_sys) disable iff (rst)
        (irq_ack && !(irq_line && !irq_line_q)) |=> !irq_latch_q) else $error("ack did not clear");
    // an enabled low input pin of the second port sets the latch
    a_merge_pin: assert property (@(posedge clk_sys) disable iff (rst)
        ((|(IRQ_OPTION & ~second_dir_q & ~second_in)) && !irq_line_q) |=> irq_latch_q) else $error("pin not merged");
    // edge-and-level mode keeps the request while the line is active
    a_level_holds: assert property (@(posedge clk_sys) disable iff (rst)
        ((TRIG_MODE == PIO_TRIG_EDGE_LEVEL) && irq_line) |-> ##2 irq_req) else $error("level not held");
    // edge-only mode requests from the latch alone
    a_edge_only: assert property (@(posedge clk_sys) disable iff (rst)
        ((TRIG_MODE == PIO_TRIG_EDGE) && !irq_latch_q) |=> !irq_sync_q) else $error("level leaked in edge mode");
endmodule
`default_nettype wire

// ---- dv/pio_board.sv ----
// pio_board: board side of one byte-wide port, resolving each pin's level
// assumes the bench sets what the board drives; pins it leaves open read high
`timescale 1ns/100ps
`default_nettype none
module pio_board (
    // device side
    input wire logic [7:0] dev_out,
    input wire logic [7:0] dev_oe,
    input wire logic [7:0] dev_pu,
    // board side
    input wire logic [7:0] brd_val,
    input wire logic [7:0] brd_en,
    output logic [7:0] lvl
);
    // ---------------------------------------------------------------
    // pin resolution
    // ---------------------------------------------------------------
    // open pins without pullup read the inverse of dev_out, which is zero on input pins, so they read high
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            lvl[b] = dev_oe[b] ? dev_out[b] : brd_en[b] ? brd_val[b] : dev_pu[b] | ~dev_out[b];
        end
    end
endmodule
`default_nettype wire

// ---- dv/pio_ports_tb_top.sv ----
// pio_ports_tb_top: register-level tests of the parallel port block
// assumes the board model per port and a 20 MHz system clock
`timescale 1ns/100ps
`default_nettype none
module pio_ports_tb_top;
    import pio_pkg::*;
    logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq_pin_n = 1, irq_ack = 0;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, rd_val, pu;
    logic [7:0] dv[3] = '{0, 0, 0}, de[3] = '{0, 0, 0}, po[3], pe[3];
    wire logic [7:0] pl[3];
    logic [6:0] fourth_in = 7'h5A, fourth_oe_allow;
    wire logic irq_req;
    logic lvl_pin_n = 1, lvl_ack = 0;
    wire logic lvl_req;
    wire logic [7:0] reg_rdata;
    int n_fail = 0, total_checks = 0;
    always #25 clk_sys = ~clk_sys;
    pio_ports #(.IRQ_OPTION(8'h01), .TRIG_MODE(1'b0)) u_pio_ports (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_in(pl[0]), .first_out(po[0]), .first_oe(pe[0]),
        .second_in(pl[1]), .second_out(po[1]), .second_oe(pe[1]), .second_pullup(pu),
        .third_in(pl[2]), .third_out(po[2]), .third_oe(pe[2]),
        .fourth_in(fourth_in), .fourth_oe_allow(fourth_oe_allow),
        .irq_pin_n(irq_pin_n), .irq_ack(irq_ack), .irq_req(irq_req));
    // one board model per bidirectional port; only the second has pullups
    for (genvar i = 0; i < 3; i++) begin : g_brd
        pio_board u_pio_board (.dev_out(po[i]), .dev_oe(pe[i]),
            .dev_pu(i == 1 ? pu : 8'h00), .brd_val(dv[i]), .brd_en(de[i]), .lvl(pl[i]));
    end
    // second device built for edge-and-level triggering, port pins idle high
    if (1) begin : g_lvl
        pio_ports #(.TRIG_MODE(PIO_TRIG_EDGE_LEVEL)) u_pio_ports (
            .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
            .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
            .first_in(8'hFF), .first_out(), .first_oe(),
            .second_in(8'hFF), .second_out(), .second_oe(), .second_pullup(),
            .third_in(8'hFF), .third_out(), .third_oe(),
            .fourth_in(fourth_in), .fourth_oe_allow(),
            .irq_pin_n(lvl_pin_n), .irq_ack(lvl_ack), .irq_req(lvl_req));
    end
    // ---------------------------------------------------------------
    // bus tasks and comparison
    // ---------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
    endtask
    // read data is taken only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1;
        rd_val = reg_rdata;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // pulse the acknowledge for one cycle
    task automatic ack();
        @(posedge clk_sys);
        irq_ack <= 1;
        @(posedge clk_sys);
        irq_ack <= 0;
    endtask
    // ---------------------------------------------------------------
    // watchdog: tests take well under 1000 cycles
    // ---------------------------------------------------------------
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        cyc(5);
        rst <= 0;
        for (int i = 0; i < 3; i++) begin
            rd(4'(i + 4)); chk(rd_val, 8'h00);
            de[i] <= 8'hFF; dv[i] <= 8'h3D;
            wr(4'(i), 8'hA5);
            rd(4'(i)); chk(rd_val, 8'h3D);
            wr(4'(i + 4), 8'h0F);
            cyc(2);
            chk(po[i], 8'h05);
            chk(pe[i], 8'h0F);
            rd(4'(i)); chk(rd_val, 8'h35);
            rd(4'(i + 4)); chk(rd_val, 8'h0F);
        end
        rd(4'h8); chk(rd_val, 8'h00);
        rd(PIO_INPUT_VALUE); chk(rd_val, 8'h5A);
        chk({1'b0, fourth_oe_allow}, 8'h00);
        wr(PIO_SERIAL_CTRL, 8'h3F); cyc(2);
        chk({1'b0, fourth_oe_allow}, 8'h3F);
        $display("ports test done");
        wr(PIO_SECOND_VALUE, 8'h01);
        de[1] <= 8'h00;
        wr(PIO_SECOND_DIR, 8'h00); cyc(2); ack(); cyc(3);
        chk(pu, 8'h01);
        chk({7'h0, irq_req}, 8'h00);
        de[1] <= 8'h01; dv[1] <= 8'h00; cyc(5);
        chk({7'h0, irq_req}, 8'h01);
        de[1] <= 8'h00; ack(); cyc(3);
        chk({7'h0, irq_req}, 8'h00);
        irq_pin_n <= 0; cyc(5);
        chk({7'h0, irq_req}, 8'h01);
        irq_pin_n <= 1; ack(); cyc(3);
        chk({7'h0, irq_req}, 8'h00);
        lvl_pin_n <= 0; cyc(5);
        chk({7'h0, lvl_req}, 8'h01);
        lvl_ack <= 1; cyc(1); lvl_ack <= 0; cyc(4);
        chk({7'h0, lvl_req}, 8'h01);
        lvl_pin_n <= 1; cyc(4);
        chk({7'h0, lvl_req}, 8'h00);
        $display("interrupt test done");
        rst <= 1; cyc(2); rst <= 0;
        rd(PIO_FIRST_DIR); chk(rd_val, 8'h00);
        chk(pe[0], 8'h00);
        chk({1'b0, fourth_oe_allow}, 8'h00);
        wr(PIO_FIRST_DIR, 8'hFF);
        rd(PIO_FIRST_VALUE); chk(rd_val, 8'hA5);
        // write then read the same direction register with no gap
        @(posedge clk_sys);
        reg_wr <= 1; reg_addr <= PIO_FIRST_DIR; reg_wdata <= 8'h3C;
        @(posedge clk_sys);
        reg_wr <= 0; reg_rd <= 1;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1;
        chk(reg_rdata, 8'h3C);
        fourth_in <= 7'h25; cyc(3);
        rd(PIO_INPUT_VALUE); chk(rd_val, 8'h25);
        $display("reset test done");
        final_report();
    end
endmodule
`default_nettype wire
